// ===== core/host_serial_string_framer.sv
// host uart framer: strings to radio, radio data and replies to host
// assumes pins synchronous to ref_clk and a radio side with valid/ready
`timescale 1ns/1ps
module host_serial_string_framer import framer_pkg::*; #(
    parameter int unsigned FIFO_DEPTH   = FIFO_DEPTH_DEF,
    parameter logic [31:0] STR_IDLE_P   = 32'(STR_IDLE_CYC),
    parameter logic [31:0] GUARD_P      = 32'(GUARD_CYC),
    parameter logic [31:0] CMD_IDLE_P   = 32'(CMD_IDLE_CYC)
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       host_rxd,
    output logic            host_txd_ff,
    input  wire logic       rts_n,
    output logic            cts_n_ff,
    input  wire logic [2:0] baud_sel,
    input  wire logic       baud_wr,
    input  wire logic       echo_setting,
    input  wire logic       link_up,
    input  wire logic       remote_disc,
    output logic            online_ff,
    output logic            flush_ff,
    output str_beat_t       str_ff,
    output logic            str_valid_ff,
    input  wire logic       str_ready,
    input  wire logic [7:0] dl_data,
    input  wire logic       dl_valid,
    output logic            dl_ready_ff
);
    localparam int unsigned PW = $clog2(FIFO_DEPTH);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_st_t;

    baud_sel_t   baud_ff;
    logic [15:0] div;
    rx_st_t      rx_st_ff;
    logic [15:0] rx_cnt_ff;
    logic [3:0]  rx_bit_ff;
    logic [7:0]  rx_sh_ff;
    logic        rx_done_ff;
    logic [31:0] idle_ff;
    logic [7:0]  mem [FIFO_DEPTH];
    logic [PW:0] wr_ff;
    logic [PW:0] rd_ff;
    logic [PW:0] count;
    logic [6:0]  str_len_ff;
    logic [6:0]  drain_ff;
    logic        kind_ff;
    logic [2:0]  esc_cnt_ff;
    logic        link_q_ff;
    logic        wr_en;
    logic [6:0]  len_nxt;
    logic        close_now;
    logic        esc_hit;
    logic        quiet_ff;
    logic        load;
    logic [9:0]  tx_sh_ff;
    logic [3:0]  tx_bits_ff;
    logic [15:0] tx_cnt_ff;
    logic [2:0]  ok_idx_ff;
    logic        echo_pend_ff;
    logic [7:0]  echo_byte_ff;
    logic        tx_start;

    // baud selection, reset default 19200
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            baud_ff <= BAUD_19200; // see (R5)
        end else if (baud_wr && baud_sel <= 3'(BAUD_115200)) begin
            baud_ff <= baud_sel_t'(baud_sel); // see (R4)
        end
    end
    assign div = baud_div(baud_ff);

    // receiver, 8 data bits, no parity, one stop bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_st_ff   <= RX_IDLE;
            rx_cnt_ff  <= 16'h0000;
            rx_bit_ff  <= 4'h0;
            rx_sh_ff   <= 8'h00;
            rx_done_ff <= 1'b0;
        end else begin
            rx_done_ff <= 1'b0;
            unique case (rx_st_ff)
                RX_IDLE: begin
                    if (!host_rxd) begin
                        rx_st_ff  <= RX_START;
                        rx_cnt_ff <= div >> 1;
                    end
                end
                RX_START: begin
                    if (rx_cnt_ff != 16'h0000) begin
                        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
                    end else begin
                        rx_st_ff  <= host_rxd ? RX_IDLE : RX_DATA;
                        rx_cnt_ff <= div - 16'h0001;
                        rx_bit_ff <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_ff != 16'h0000) begin
                        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
                    end else begin
                        rx_sh_ff  <= {host_rxd, rx_sh_ff[7:1]}; // see (R3)
                        rx_cnt_ff <= div - 16'h0001;
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (rx_bit_ff == 4'(DATA_BITS - 1)) begin
                            rx_st_ff <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_ff != 16'h0000) begin
                        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
                    end else begin
                        rx_st_ff   <= RX_IDLE;
                        rx_done_ff <= host_rxd; // see (R3)
                    end
                end
            endcase
        end
    end

    // cycles of line silence since the last host character
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            idle_ff <= 32'h0000_0000;
        end else if (rx_done_ff || rx_st_ff != RX_IDLE) begin
            idle_ff <= 32'h0000_0000;
        end else if (idle_ff != 32'hFFFF_FFFF) begin
            idle_ff <= idle_ff + 32'h0000_0001;
        end
    end

    // silence seen before the start bit of this character
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            quiet_ff <= 1'b0;
        end else if (rx_st_ff == RX_IDLE && !host_rxd) begin
            quiet_ff <= idle_ff >= GUARD_P; // see (R6)
        end
    end

    // string close and escape decisions
    assign count   = wr_ff - rd_ff;
    assign esc_hit = online_ff && esc_cnt_ff == ESC_PLUSES && idle_ff >= GUARD_P && !rx_done_ff; // see (R6)
    assign wr_en   = rx_done_ff && count != (PW + 1)'(FIFO_DEPTH); // see (R7) (R19)
    assign len_nxt = str_len_ff + 7'(wr_en);
    always_comb begin
        if (online_ff) begin
            close_now = (wr_en && len_nxt == 7'(ONLINE_MAX)) // see (R10)
                || (!rx_done_ff && idle_ff == STR_IDLE_P && str_len_ff != 7'h00
                    && esc_cnt_ff == 3'h0); // see (R9)
        end else begin
            close_now = (wr_en && (rx_sh_ff == CHAR_CR // see (R12)
                || len_nxt == 7'(OFFLINE_MAX))) // see (R14)
                || (!rx_done_ff && idle_ff == CMD_IDLE_P && str_len_ff != 7'h00); // see (R13)
        end
    end
    assign load = drain_ff != 7'h00 && (!str_valid_ff || str_ready);

    // storage of host characters
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_ff[PW-1:0]] <= rx_sh_ff;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ff <= '0;
        end else if (wr_en) begin
            wr_ff <= wr_ff + 1'b1;
        end
    end

    // escape detector
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            esc_cnt_ff <= 3'h0;
        end else if (!online_ff || esc_hit) begin
            esc_cnt_ff <= 3'h0;
        end else if (rx_done_ff) begin
            if (rx_sh_ff != CHAR_PLUS || esc_cnt_ff == ESC_PLUSES) begin
                esc_cnt_ff <= 3'h0; // see (R21)
            end else if (esc_cnt_ff != 3'h0) begin
                esc_cnt_ff <= esc_cnt_ff + 3'h1;
            end else if (quiet_ff && str_len_ff == 7'h00) begin
                esc_cnt_ff <= 3'h1; // see (R6)
            end
        end
    end

    // string accounting and stream toward the radio
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            str_len_ff   <= 7'h00;
            drain_ff     <= 7'h00;
            kind_ff      <= 1'b1;
            rd_ff        <= '0;
            str_ff       <= '0;
            str_valid_ff <= 1'b0;
        end else if (esc_hit) begin
            str_len_ff   <= 7'h00; // see (R22)
            drain_ff     <= 7'h00; // see (R20)
            rd_ff        <= wr_ff;
            str_valid_ff <= 1'b0;
        end else begin
            str_len_ff <= close_now ? 7'h00 : len_nxt;
            drain_ff   <= drain_ff + (close_now ? len_nxt : 7'h00) - 7'(load);
            if (close_now) begin
                kind_ff <= !online_ff;
            end
            if (load) begin
                str_ff.data  <= mem[rd_ff[PW-1:0]];
                str_ff.last  <= drain_ff == 7'h01;
                str_ff.cmd   <= kind_ff;
                str_valid_ff <= 1'b1;
                rd_ff        <= rd_ff + 1'b1;
            end else if (str_ready) begin
                str_valid_ff <= 1'b0;
            end
        end
    end

    // flow control toward the host
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cts_n_ff <= 1'b0;
        end else begin
            cts_n_ff <= close_now || drain_ff != 7'h00 // see (R17) (R16)
                || count >= (PW + 1)'(FIFO_DEPTH - FC_HEADROOM); // see (R19)
        end
    end

    // mode control
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            online_ff <= 1'b0; // see (R1)
            link_q_ff <= 1'b0;
            flush_ff  <= 1'b0;
        end else begin
            link_q_ff <= link_up;
            flush_ff  <= esc_hit; // see (R20)
            if (esc_hit || remote_disc || !link_up) begin
                online_ff <= 1'b0; // see (R2)
            end else if (link_up && !link_q_ff) begin
                online_ff <= 1'b1; // see (R2)
            end
        end
    end

    // transmitter: OK reply, then echo, then radio data
    assign tx_start = tx_bits_ff == 4'h0 && !rts_n;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_sh_ff     <= 10'h3FF;
            tx_bits_ff   <= 4'h0;
            tx_cnt_ff    <= 16'h0000;
            ok_idx_ff    <= OK_LEN;
            echo_pend_ff <= 1'b0;
            echo_byte_ff <= 8'h00;
            dl_ready_ff  <= 1'b0;
            host_txd_ff  <= 1'b1;
        end else begin
            dl_ready_ff <= 1'b0;
            if (!online_ff && rx_done_ff && echo_setting) begin
                echo_pend_ff <= 1'b1; // see (R15) (R8)
                echo_byte_ff <= rx_sh_ff;
            end
            if (esc_hit) begin
                ok_idx_ff <= 3'h0; // see (R20)
            end
            if (tx_bits_ff != 4'h0) begin
                if (tx_cnt_ff != 16'h0000) begin
                    tx_cnt_ff <= tx_cnt_ff - 16'h0001;
                end else begin
                    host_txd_ff <= tx_sh_ff[0];
                    tx_sh_ff    <= {1'b1, tx_sh_ff[9:1]};
                    tx_bits_ff  <= tx_bits_ff - 4'h1;
                    tx_cnt_ff   <= div - 16'h0001;
                end
            end else if (tx_start && !esc_hit) begin // see (R18)
                tx_cnt_ff <= 16'h0000;
                if (ok_idx_ff != OK_LEN) begin
                    tx_sh_ff   <= {1'b1, ok_char(ok_idx_ff), 1'b0};
                    tx_bits_ff <= 4'(FRAME_BITS + 1);
                    ok_idx_ff  <= ok_idx_ff + 3'h1;
                end else if (echo_pend_ff && !(rx_done_ff && echo_setting && !online_ff)) begin
                    tx_sh_ff     <= {1'b1, echo_byte_ff, 1'b0};
                    tx_bits_ff   <= 4'(FRAME_BITS + 1);
                    echo_pend_ff <= 1'b0;
                end else if (dl_ready_ff && dl_valid) begin
                    tx_sh_ff   <= {1'b1, dl_data, 1'b0}; // see (R11)
                    tx_bits_ff <= 4'(FRAME_BITS + 1); // full stop bit
                end else begin
                    dl_ready_ff <= online_ff && !echo_pend_ff && !dl_ready_ff;
                end
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence esc_seen_s;
        esc_hit;
    endsequence
    sequence ok_reply_s;
        !online_ff && flush_ff && ok_idx_ff == 3'h0;
    endsequence
    sequence cr_in_s;
        !online_ff && wr_en && rx_sh_ff == CHAR_CR;
    endsequence

    escape_reply_a: assert property (esc_seen_s |=> ok_reply_s) // see (R6) (R20)
        else $error("escape did not go offline with OK reply");
    escape_flush_a: assert property (esc_seen_s |=> !str_valid_ff && drain_ff == 7'h00 ##1 !flush_ff) // see (R22)
        else $error("escape left radio data pending");
    cr_close_a: assert property (cr_in_s |=> str_len_ff == 7'h00 && drain_ff != 7'h00 && cts_n_ff) // see (R12)
        else $error("carriage return did not close command");
    online_len_a: assert property (online_ff |-> str_len_ff < 7'(ONLINE_MAX)) // see (R10)
        else $error("online string longer than limit");
    offline_len_a: assert property (!online_ff && !$past(online_ff) |-> str_len_ff < 7'(OFFLINE_MAX)) // see (R14)
        else $error("command string longer than limit");
    no_echo_a: assert property (online_ff && rx_done_ff && !echo_pend_ff |=> !echo_pend_ff) // see (R8)
        else $error("echo raised in online mode");
    echo_on_a: assert property (!online_ff && rx_done_ff && echo_setting |=> echo_pend_ff) // see (R15)
        else $error("offline echo missing");
    rts_hold_a: assert property ($rose(tx_bits_ff != 4'h0) |-> $past(!rts_n)) // see (R18)
        else $error("frame started while rts high");
    radio_pass_a: assert property (dl_ready_ff && dl_valid && tx_start |=> tx_sh_ff[8:1] == $past(dl_data)) // see (R11)
        else $error("radio byte altered");
    idle_close_a: assert property (online_ff && close_now && !wr_en |=> cts_n_ff && drain_ff != 7'h00) // see (R9)
        else $error("idle close did not raise flow control");
endmodule : host_serial_string_framer

// ===== include/framer_pkg.sv
// constants, types and timing for the host serial string framer
// assumes one 100 MHz core clock and synchronous host pins
// What this block does
// (R1) power-up starts in offline command mode
// (R2) online on link up; leave on escape/disconnect/loss
// (R3) host characters are 8N1
// (R4) baud selectable 9600 to 115200
// (R5) baud defaults to 19200 after reset
// (R6) guarded +++ switches online to offline
// (R7) online accepts all byte values as payload
// (R8) no echo to host in online mode
// (R9) online 14 ms idle closes and sends string
// (R10) online string closes at 47 characters
// (R11) radio data reaches host unchanged
// (R12) offline carriage return closes command string
// (R13) offline 30 s idle closes command string
// (R14) offline command closes at 23 characters
// (R15) offline echo only when echo setting is 1
// (R16) rxd, txd plus rts/cts flow control pair
// (R17) cts low accepts data, high refuses it
// (R18) no transmit to host while rts high
// (R19) store 17 more characters after flow control
// (R20) escape flushes radio side, replies OK CR LF
// (R21) non-plus inside escape cancels, data kept
// (R22) completed escape pluses never sent by radio
package framer_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned FRAME_BITS    = DATA_BITS + 2;
    localparam int unsigned STR_IDLE_US   = 14_000;
    localparam int unsigned STR_IDLE_CYC  = STR_IDLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned GUARD_MS      = 1000;
    localparam int unsigned GUARD_CYC     = GUARD_MS * (CLK_HZ / 1000);
    localparam int unsigned CMD_IDLE_S    = 30;
    localparam longint unsigned CMD_IDLE_CYC = 64'(CMD_IDLE_S) * 64'(CLK_HZ);
    localparam int unsigned ONLINE_MAX    = 47;
    localparam int unsigned OFFLINE_MAX   = 23;
    localparam int unsigned FC_HEADROOM   = 17;
    localparam int unsigned FIFO_DEPTH_DEF = 64;
    localparam logic [7:0]  CHAR_PLUS     = 8'h2B;
    localparam logic [7:0]  CHAR_CR       = 8'h0D;
    localparam logic [7:0]  CHAR_LF       = 8'h0A;
    localparam logic [7:0]  CHAR_O        = 8'h4F;
    localparam logic [7:0]  CHAR_K        = 8'h4B;
    localparam logic [2:0]  ESC_PLUSES    = 3'h3;
    localparam logic [2:0]  OK_LEN        = 3'h4;

    typedef enum logic [2:0] {
        BAUD_9600, BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200
    } baud_sel_t;

    typedef struct packed {
        logic       cmd;
        logic       last;
        logic [7:0] data;
    } str_beat_t;

    function automatic logic [15:0] baud_div(input baud_sel_t s);
        unique case (s)
            BAUD_9600:   baud_div = 16'(CLK_HZ / 9600);
            BAUD_19200:  baud_div = 16'(CLK_HZ / 19200);
            BAUD_38400:  baud_div = 16'(CLK_HZ / 38400);
            BAUD_57600:  baud_div = 16'(CLK_HZ / 57600);
            BAUD_115200: baud_div = 16'(CLK_HZ / 115200);
            default:     baud_div = 16'(CLK_HZ / 19200);
        endcase
    endfunction : baud_div

    function automatic logic [7:0] ok_char(input logic [2:0] i);
        unique case (i)
            3'h0:    ok_char = CHAR_O;
            3'h1:    ok_char = CHAR_K;
            3'h2:    ok_char = CHAR_CR;
            default: ok_char = CHAR_LF;
        endcase
    endfunction : ok_char
endpackage : framer_pkg

// ===== test/host_uart_model.sv
// host microcontroller model: 8n1 sender, receiver and rts control
// assumes the bench sets div to the bit time in ref_clk cycles
`timescale 1ns/1ps
module host_uart_model import framer_pkg::*; (
    input  wire logic ref_clk,
    output logic      host_rxd,
    input  wire logic host_txd,
    output logic      rts_n,
    input  wire logic cts_n
);
    int unsigned div;
    int unsigned stop_errs;
    logic [7:0]  rx_q[$];

    initial begin
        div       = CLK_HZ / 19200;
        stop_errs = 0;
        host_rxd  = 1'b1;
        rts_n     = 1'b0;
    end

    // low lets the device talk, high stops it
    task automatic set_rts(input logic stop);
        @(posedge ref_clk);
        rts_n <= stop;
    endtask : set_rts

    task automatic send_byte(input logic [7:0] b);
        logic [9:0]  frame;
        int unsigned k;
        frame = {1'b1, b, 1'b0};
        k     = 0;
        while (cts_n !== 1'b0 && k < 200000) begin
            @(posedge ref_clk);
            k++;
        end
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            host_rxd <= frame[i];
            repeat (div - 1) @(posedge ref_clk);
        end
    endtask : send_byte

    // receiver: waits to mid start bit without checking it, lsb first, stop must be high
    initial begin
        logic [7:0] d;
        forever begin
            @(posedge ref_clk);
            if (host_txd === 1'b0) begin
                repeat (div / 2) @(posedge ref_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (div) @(posedge ref_clk);
                    d[i] = host_txd;
                end
                repeat (div) @(posedge ref_clk);
                if (host_txd !== 1'b1) stop_errs++;
                rx_q.push_back(d);
            end
        end
    end
endmodule : host_uart_model

// ===== test/testbench.sv
// self-checking bench for the host serial string framer
// assumes framer_pkg and the host model are compiled first
`timescale 1ns/1ps
module testbench import framer_pkg::*; ;
    localparam logic [31:0] STR_IDLE_T = 32'h0000_2710;
    localparam logic [31:0] GUARD_T    = 32'h0000_01F4;
    localparam logic [31:0] CMD_IDLE_T = 32'h0003_0D40;

    logic        ref_clk, rst, host_rxd, host_txd_ff, rts_n, cts_n_ff, baud_wr;
    logic        echo_setting, link_up, remote_disc, online_ff, flush_ff;
    logic        str_valid_ff, str_ready, dl_valid, dl_ready_ff;
    logic [2:0]  baud_sel;
    logic [7:0]  dl_data;
    str_beat_t   str_ff;
    str_beat_t   beats[$];
    int unsigned bad_count, comparisons, flush_seen, cts_seen;

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    host_serial_string_framer #(
        .FIFO_DEPTH (FIFO_DEPTH_DEF),
        .STR_IDLE_P (STR_IDLE_T),
        .GUARD_P    (GUARD_T),
        .CMD_IDLE_P (CMD_IDLE_T)
    ) u_host_serial_string_framer (
        .ref_clk(ref_clk), .rst(rst), .host_rxd(host_rxd), .host_txd_ff(host_txd_ff),
        .rts_n(rts_n), .cts_n_ff(cts_n_ff), .baud_sel(baud_sel), .baud_wr(baud_wr),
        .echo_setting(echo_setting), .link_up(link_up), .remote_disc(remote_disc),
        .online_ff(online_ff), .flush_ff(flush_ff), .str_ff(str_ff), .str_valid_ff(str_valid_ff),
        .str_ready(str_ready), .dl_data(dl_data), .dl_valid(dl_valid), .dl_ready_ff(dl_ready_ff)
    );

    host_uart_model u_host_uart_model (
        .ref_clk(ref_clk), .host_rxd(host_rxd), .host_txd(host_txd_ff), .rts_n(rts_n), .cts_n(cts_n_ff)
    );

    // radio side takes a beat every other cycle
    always @(posedge ref_clk) begin
        if (str_valid_ff === 1'b1 && str_ready === 1'b1) beats.push_back(str_ff);
        if (flush_ff === 1'b1) flush_seen++;
        if (cts_n_ff === 1'b1) cts_seen++;
        str_ready <= ~str_ready;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] pop_beat();
        return 32'(beats.pop_front());
    endfunction : pop_beat

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    // what: 0 host bytes received, 1 radio beats, 2 offline
    task automatic wait_until(input int what, input int n, input int bound);
        int k;
        k = 0;
        while (k < bound && !(what == 0 ? u_host_uart_model.rx_q.size() >= n :
                              what == 1 ? beats.size() >= n : online_ff === 1'b0)) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= bound) begin
            bad_count++;
            $display("Error at %0t: wait %0d ran out", $time, what);
            final_report();
        end
    endtask : wait_until

    task automatic t_reset();
        check(32'(online_ff), 0, "online after reset");
        check(32'(cts_n_ff), 0, "cts after reset");
        check(32'(host_txd_ff), 1, "txd idle");
        $display("test reset done");
    endtask : t_reset

    task automatic t_default_baud();
        u_host_uart_model.send_byte(CHAR_CR);
        wait_until(1, 1, 70000);
        check(pop_beat(), 32'({2'b11, CHAR_CR}), "cr closes command");
        repeat (200) @(posedge ref_clk);
        check(32'(u_host_uart_model.rx_q.size()), 0, "echo while setting 0");
        $display("test default baud done");
    endtask : t_default_baud

    task automatic t_echo();
        @(posedge ref_clk);
        baud_sel     <= 3'h4;
        baud_wr      <= 1'b1;
        echo_setting <= 1'b1;
        @(posedge ref_clk);
        baud_wr <= 1'b0;
        u_host_uart_model.div = CLK_HZ / 115200;
        u_host_uart_model.send_byte(8'hA5);
        u_host_uart_model.send_byte(CHAR_CR);
        wait_until(0, 2, 40000);
        wait_until(1, 2, 1000);
        check(32'(u_host_uart_model.rx_q[0]), 32'h0000_00A5, "echo 0");
        check(32'(u_host_uart_model.rx_q[1]), 32'(CHAR_CR), "echo 1");
        check(pop_beat(), 32'({2'b10, 8'hA5}), "command byte");
        check(pop_beat(), 32'({2'b11, CHAR_CR}), "command end");
        check(u_host_uart_model.stop_errs, 0, "stop bits");
        $display("test echo done");
    endtask : t_echo

    task automatic t_online();
        u_host_uart_model.rx_q.delete();
        @(posedge ref_clk);
        link_up <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(32'(online_ff), 1, "online on link");
        cts_seen = 0;
        u_host_uart_model.send_byte(8'h00);
        u_host_uart_model.send_byte(8'hFF);
        wait_until(1, 2, 30000);
        check(pop_beat(), 32'h0000_0000, "payload 00");
        check(pop_beat(), 32'({2'b01, 8'hFF}), "idle close");
        check(32'(cts_seen != 0), 1, "flow control on close");
        check(32'(u_host_uart_model.rx_q.size()), 0, "no online echo");
        $display("test online done");
    endtask : t_online

    task automatic t_downlink();
        int k;
        u_host_uart_model.set_rts(1'b1);
        @(posedge ref_clk);
        dl_data  <= 8'h3C;
        dl_valid <= 1'b1;
        k = 0;
        repeat (100) begin
            @(negedge ref_clk);
            if (dl_ready_ff === 1'b1) k++;
        end
        check(32'(k), 0, "taken while rts high");
        u_host_uart_model.set_rts(1'b0);
        k = 0;
        while (dl_ready_ff !== 1'b1 && k < 1000) begin
            @(negedge ref_clk);
            k++;
        end
        check(32'(k < 1000), 1, "ready after rts low");
        @(posedge ref_clk);
        dl_valid <= 1'b0;
        wait_until(0, 1, 12000);
        check(32'(u_host_uart_model.rx_q[0]), 32'h0000_003C, "radio byte to host");
        $display("test downlink done");
    endtask : t_downlink

    task automatic t_escape();
        u_host_uart_model.rx_q.delete();
        flush_seen = 0;
        repeat (GUARD_T + 100) @(posedge ref_clk);
        repeat (3) u_host_uart_model.send_byte(CHAR_PLUS);
        wait_until(2, 0, 20000);
        wait_until(0, 4, 40000);
        check(32'(flush_seen), 1, "flush pulse");
        check(32'({u_host_uart_model.rx_q[0], u_host_uart_model.rx_q[1]}), 32'h0000_4F4B, "ok");
        check(32'({u_host_uart_model.rx_q[2], u_host_uart_model.rx_q[3]}), 32'h0000_0D0A, "crlf");
        check(32'(beats.size()), 0, "pluses kept off radio");
        check(u_host_uart_model.stop_errs, 0, "reply stop bits");
        $display("test escape done");
    endtask : t_escape

    task automatic t_disc();
        @(posedge ref_clk);
        link_up <= 1'b0;
        repeat (3) @(posedge ref_clk);
        link_up <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(32'(online_ff), 1, "online again");
        remote_disc <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(32'(online_ff), 0, "remote disconnect");
        remote_disc <= 1'b0;
        link_up     <= 1'b0;
        $display("test disconnect done");
    endtask : t_disc

    initial begin
        bad_count    = 0;
        comparisons  = 0;
        flush_seen   = 0;
        cts_seen     = 0;
        rst          = 1'b1;
        baud_sel     = 3'h1;
        baud_wr      = 1'b0;
        echo_setting = 1'b0;
        link_up      = 1'b0;
        remote_disc  = 1'b0;
        str_ready    = 1'b0;
        dl_valid     = 1'b0;
        dl_data      = 8'h00;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_default_baud();
        t_echo();
        t_online();
        t_downlink();
        t_escape();
        t_disc();
        final_report();
    end
endmodule : testbench
